// File: src/pfc_pkg.sv
// Package: types, register map and constants of the playback filter configuration
package pfc_pkg;

  // Datapath widths
  localparam int PFC_SMP_W       = 24;
  localparam int PFC_COEF_W      = 16;
  localparam int PFC_FRAC_W      = 16;
  localparam int PFC_ACC_W       = PFC_SMP_W + PFC_FRAC_W;
  localparam int PFC_COEF_FRAC   = 14;
  localparam int PFC_GAIN_FRAC   = 12;
  localparam int PFC_GAIN_W      = 15;
  localparam int PFC_STAGES      = 5;
  localparam int PFC_STAGE_COEFS = 5;
  localparam int PFC_BANDS       = 5;
  localparam int PFC_STORE_BYTES = 64;
  localparam int PFC_ADDR_W      = 8;

  typedef logic signed [PFC_SMP_W-1:0] pfc_smp_t;
  typedef logic [PFC_COEF_W-1:0]       pfc_coef_t;

  typedef struct packed {
    pfc_coef_t b0;
    pfc_coef_t b1;
    pfc_coef_t b2;
    pfc_coef_t a1;
    pfc_coef_t a2;
  } pfc_coef_set_s;

  typedef struct packed {
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [PFC_ADDR_W-1:0] paddr;
    logic [31:0]           pwdata;
  } pfc_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } pfc_apb_rsp_s;

  // Register indices; byte address is four times the index
  localparam logic [5:0] PFC_IDX_HPF   = 6'h24;
  localparam logic [5:0] PFC_IDX_EQ12  = 6'h25;
  localparam logic [5:0] PFC_IDX_EQ34  = 6'h26;
  localparam logic [5:0] PFC_IDX_EQ5   = 6'h27;
  localparam logic [5:0] PFC_IDX_BIQC  = 6'h28;
  localparam logic [5:0] PFC_IDX_BIQD  = 6'h29;
  localparam logic [5:0] PFC_IDX_BIQA  = 6'h2a;

  // Field positions
  localparam int PFC_HPF_EN_BIT   = 7;
  localparam int PFC_AUDIO_LSB    = 4;
  localparam int PFC_VOICE_EN_BIT = 3;
  localparam int PFC_VOICE_LSB    = 0;
  localparam int PFC_HI_GAIN_LSB  = 4;
  localparam int PFC_EQ_EN_BIT    = 7;
  localparam int PFC_BIQ_EN_BIT   = 7;
  localparam int PFC_BIQ_MUTE_BIT = 6;

  // Reset values
  localparam logic       PFC_RST_HPF_EN   = 1'h1;
  localparam logic [1:0] PFC_RST_AUDIO    = 2'h0;
  localparam logic       PFC_RST_VOICE_EN = 1'h0;
  localparam logic [2:0] PFC_RST_VOICE    = 3'h0;
  localparam logic [3:0] PFC_RST_GAIN     = 4'h7;
  localparam logic       PFC_RST_EQ_EN    = 1'h0;
  localparam logic       PFC_RST_BIQ_EN   = 1'h0;
  localparam logic       PFC_RST_BIQ_MUTE = 1'h1;
  localparam logic [7:0] PFC_RST_BYTE     = 8'h00;
  localparam logic [5:0] PFC_RST_INDEX    = 6'h00;

  // One-pole shift per corner code; element 0 is code 0
  localparam logic [3:0][3:0] PFC_AUDIO_SHIFT = {4'h9, 4'ha, 4'hb, 4'hc};
  localparam logic [7:0][3:0] PFC_VOICE_SHIFT =
    {4'h2, 4'h2, 4'h3, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9};
  // Band split low-pass shifts, lowest band first
  localparam logic [3:0][3:0] PFC_SPLIT_SHIFT = {4'h1, 4'h3, 4'h5, 4'h7};
  localparam int PFC_EQ_ATTEN_SHIFT = 2;
  // Linear band gain, unity is 0x1000, -10.5 dB to +12 dB in 1.5 dB steps
  localparam logic [15:0][PFC_GAIN_W-1:0] PFC_GAIN_LUT = {
    15'h3fb2, 15'h3598, 15'h2d18, 15'h25f1, 15'h1fed, 15'h1adc, 15'h169a, 15'h1304,
    15'h1000, 15'h0d76, 15'h0b54, 15'h0988, 15'h0805, 15'h06bf, 15'h05ad, 15'h04c7};

endpackage

// File: src/pfc_hpf.sv
// One-pole high-pass section with a shift-selected corner
`timescale 1ns/1ps
module pfc_hpf (
  // Clock and reset
  input  wire logic            sys_clk,
  input  wire logic            rst,
  // Control
  input  wire logic            en,
  input  wire logic [3:0]      shift,
  input  wire logic            step,
  // Samples
  input  wire pfc_pkg::pfc_smp_t x,
  output      pfc_pkg::pfc_smp_t y
);
  import pfc_pkg::*;

  typedef struct packed {
    logic [PFC_ACC_W-1:0] lp;
  } pfc_hpf_st_s;

  pfc_hpf_st_s st_q;
  pfc_hpf_st_s st_d;
  logic signed [PFC_ACC_W-1:0] xe;
  logic signed [PFC_ACC_W-1:0] diff;

  // Corner follows the sample rate since the filter advances once per sample
  always_comb begin
    xe   = $signed({x, {PFC_FRAC_W{1'b0}}});
    diff = xe - $signed(st_q.lp);
    st_d = st_q;
    if (!en) begin
      st_d.lp = '0;
    end else if (step) begin
      // Signed sum keeps the shift arithmetic for falling input
      st_d.lp = $unsigned($signed(st_q.lp) + (diff >>> shift));
    end
  end

  assign y = en ? x - $signed(st_q.lp[PFC_ACC_W-1:PFC_FRAC_W]) : x;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule

// File: src/pfc_biquad.sv
// One direct-form biquad stage with bypass when disabled
`timescale 1ns/1ps
module pfc_biquad (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // Control
  input  wire logic                  en,
  input  wire logic                  step,
  input  wire pfc_pkg::pfc_coef_set_s coef,
  // Samples
  input  wire pfc_pkg::pfc_smp_t     x,
  output      pfc_pkg::pfc_smp_t     y
);
  import pfc_pkg::*;

  localparam int ACC_W = PFC_SMP_W + PFC_COEF_W + 4;

  typedef struct packed {
    pfc_smp_t x1;
    pfc_smp_t x2;
    pfc_smp_t y1;
    pfc_smp_t y2;
  } pfc_biq_st_s;

  pfc_biq_st_s st_q;
  pfc_biq_st_s st_d;
  logic signed [ACC_W-1:0] acc;
  pfc_smp_t                yf;

  always_comb begin
    acc = ACC_W'($signed(coef.b0) * x)
        + ACC_W'($signed(coef.b1) * $signed(st_q.x1))
        + ACC_W'($signed(coef.b2) * $signed(st_q.x2))
        - ACC_W'($signed(coef.a1) * $signed(st_q.y1))
        - ACC_W'($signed(coef.a2) * $signed(st_q.y2));
    yf   = acc[PFC_COEF_FRAC+PFC_SMP_W-1:PFC_COEF_FRAC];
    st_d = st_q;
    if (!en) begin
      st_d = '0;
    end else if (step) begin
      st_d.x1 = x;
      st_d.x2 = st_q.x1;
      st_d.y1 = yf;
      st_d.y2 = st_q.y1;
    end
  end

  assign y = en ? yf : x;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule

// File: src/pfc_top.sv
// Playback filter chain with its APB configuration registers
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
module pfc_top (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // APB slave
  input  wire pfc_pkg::pfc_apb_req_s apb_req,
  output      pfc_pkg::pfc_apb_rsp_s apb_rsp,
  // Sample input
  input  wire logic                 smp_in_valid,
  input  wire pfc_pkg::pfc_smp_t    smp_in,
  // Sample output
  output      logic                 smp_out_valid,
  output      pfc_pkg::pfc_smp_t    smp_out
);
  import pfc_pkg::*;

  localparam int BAND_W = PFC_SMP_W + 1;
  localparam int PROD_W = BAND_W + PFC_GAIN_W + 1;
  localparam int SUM_W  = PROD_W + 3;

  typedef struct packed {
    logic                                   hpf_en;
    logic [1:0]                             audio_corner;
    logic                                   voice_en;
    logic [2:0]                             voice_corner;
    logic [PFC_BANDS-1:0][3:0]              equaliser_gain;
    logic                                   equaliser_enable;
    logic                                   biquad_chain_enable;
    logic                                   biquad_chain_mute;
    logic [7:0]                             biquad_coeff_byte;
    logic [5:0]                             biquad_coeff_index;
    logic [PFC_STORE_BYTES-1:0][7:0]        store;
    logic [PFC_BANDS-2:0][PFC_ACC_W-1:0]    eq_lp;
    logic [31:0]                            rd;
    logic                                   out_valid;
    pfc_smp_t                               out_data;
  } pfc_top_st_s;

  pfc_top_st_s st_q;
  pfc_top_st_s st_d;

  // Bus decode
  logic [5:0]  idx;
  logic        hit;
  logic        setup;
  logic        access;
  logic        wr;
  logic [31:0] rd_val;
  logic [31:0] wd;

  assign idx    = apb_req.paddr[7:2];
  assign setup  = apb_req.psel & ~apb_req.penable;
  assign access = apb_req.psel & apb_req.penable;
  assign wd     = apb_req.pwdata;

  always_comb begin
    hit = 1'b0;
    if (apb_req.paddr[1:0] == 2'h0) begin
      case (idx)
        PFC_IDX_HPF, PFC_IDX_EQ12, PFC_IDX_EQ34, PFC_IDX_EQ5,
        PFC_IDX_BIQC, PFC_IDX_BIQD, PFC_IDX_BIQA: hit = 1'b1;
        default: hit = 1'b0;
      endcase
    end
  end

  assign wr = access & apb_req.pwrite & hit;

  // Read view; reserved bits read as zero
  always_comb begin
    rd_val = '0;
    case (idx)
      PFC_IDX_HPF: begin
        rd_val[PFC_HPF_EN_BIT]                    = st_q.hpf_en;
        rd_val[PFC_AUDIO_LSB+:2]                  = st_q.audio_corner;
        rd_val[PFC_VOICE_EN_BIT]                  = st_q.voice_en;
        rd_val[PFC_VOICE_LSB+:3]                  = st_q.voice_corner;
      end
      PFC_IDX_EQ12: begin
        rd_val[3:0]                               = st_q.equaliser_gain[0];
        rd_val[PFC_HI_GAIN_LSB+:4]                = st_q.equaliser_gain[1];
      end
      PFC_IDX_EQ34: begin
        rd_val[3:0]                               = st_q.equaliser_gain[2];
        rd_val[PFC_HI_GAIN_LSB+:4]                = st_q.equaliser_gain[3];
      end
      PFC_IDX_EQ5: begin
        rd_val[PFC_EQ_EN_BIT]                     = st_q.equaliser_enable;
        rd_val[3:0]                               = st_q.equaliser_gain[4];
      end
      PFC_IDX_BIQC: begin
        rd_val[PFC_BIQ_EN_BIT]                    = st_q.biquad_chain_enable;
        rd_val[PFC_BIQ_MUTE_BIT]                  = st_q.biquad_chain_mute;
      end
      PFC_IDX_BIQD: rd_val[7:0]                   = st_q.biquad_coeff_byte;
      PFC_IDX_BIQA: rd_val[5:0]                   = st_q.biquad_coeff_index;
      default: rd_val = '0;
    endcase
    if (apb_req.paddr[1:0] != 2'h0) begin
      rd_val = '0;
    end
  end

  assign apb_rsp.prdata  = st_q.rd;
  assign apb_rsp.pready  = access;
  assign apb_rsp.pslverr = access & ~hit;

  // Sample chain
  logic [3:0] audio_shift;
  logic [3:0] voice_shift;
  pfc_smp_t   x_audio;
  pfc_smp_t   x_voice;
  pfc_smp_t   x_eq;
  pfc_smp_t   x_final;
  pfc_smp_t   biq_x [PFC_STAGES+1];
  pfc_coef_set_s coef [PFC_STAGES];

  assign audio_shift = PFC_AUDIO_SHIFT[st_q.audio_corner];
  assign voice_shift = PFC_VOICE_SHIFT[st_q.voice_corner];

  pfc_hpf u_audio_hpf (
    .sys_clk (sys_clk),
    .rst     (rst),
    .en      (st_q.hpf_en),
    .shift   (audio_shift),
    .step    (smp_in_valid),
    .x       (smp_in),
    .y       (x_audio)
  );

  pfc_hpf u_voice_hpf (
    .sys_clk (sys_clk),
    .rst     (rst),
    .en      (st_q.voice_en),
    .shift   (voice_shift),
    .step    (smp_in_valid),
    .x       (x_audio),
    .y       (x_voice)
  );

  // Equaliser: low-pass splits form five bands that sum back to the input
  logic signed [BAND_W-1:0] band [PFC_BANDS];
  logic signed [PROD_W-1:0] prod [PFC_BANDS];
  logic signed [SUM_W-1:0]  eq_sum;
  pfc_smp_t                 lpv  [PFC_BANDS-1];

  genvar b;
  generate
    for (b = 0; b < PFC_BANDS; b = b + 1) begin : g_band
      if (b < PFC_BANDS - 1) begin : g_lp
        assign lpv[b] = st_q.eq_lp[b][PFC_ACC_W-1:PFC_FRAC_W];
      end
      if (b == 0) begin : g_low
        assign band[b] = BAND_W'(lpv[0]);
      end else if (b == PFC_BANDS - 1) begin : g_high
        assign band[b] = BAND_W'(x_voice) - BAND_W'(lpv[b-1]);
      end else begin : g_mid
        assign band[b] = BAND_W'(lpv[b]) - BAND_W'(lpv[b-1]);
      end
      assign prod[b] = band[b]
        * $signed({1'b0, PFC_GAIN_LUT[st_q.equaliser_gain[b]]});
    end
  endgenerate

  always_comb begin
    eq_sum = '0;
    for (int i = 0; i < PFC_BANDS; i++) begin
      eq_sum = eq_sum + SUM_W'(prod[i]);
    end
  end

  localparam int EQ_SHIFT = PFC_GAIN_FRAC + PFC_EQ_ATTEN_SHIFT;
  assign x_eq = st_q.equaliser_enable
    ? eq_sum[EQ_SHIFT+PFC_SMP_W-1:EQ_SHIFT]
    : x_voice;

  // Biquad chain fed from the coefficient store
  assign biq_x[0] = x_eq;

  genvar s;
  generate
    for (s = 0; s < PFC_STAGES; s = s + 1) begin : g_stage
      localparam int K = s * PFC_STAGE_COEFS;
      assign coef[s].b0 = {st_q.store[2*K+1], st_q.store[2*K]};
      assign coef[s].b1 = {st_q.store[2*K+3], st_q.store[2*K+2]};
      assign coef[s].b2 = {st_q.store[2*K+5], st_q.store[2*K+4]};
      assign coef[s].a1 = {st_q.store[2*K+7], st_q.store[2*K+6]};
      assign coef[s].a2 = {st_q.store[2*K+9], st_q.store[2*K+8]};
      pfc_biquad u_biquad (
        .sys_clk (sys_clk),
        .rst     (rst),
        .en      (st_q.biquad_chain_enable),
        .step    (smp_in_valid),
        .coef    (coef[s]),
        .x       (biq_x[s]),
        .y       (biq_x[s+1])
      );
    end
  endgenerate

  // Mute acts on the running chain only
  assign x_final = (st_q.biquad_chain_enable && st_q.biquad_chain_mute)
    ? '0
    : biq_x[PFC_STAGES];

  // State update
  logic signed [PFC_ACC_W-1:0] xe;
  logic [5:0]                  ci;

  always_comb begin
    st_d = st_q;
    xe   = $signed({x_voice, {PFC_FRAC_W{1'b0}}});
    ci   = st_q.biquad_coeff_index;
    if (setup) begin
      st_d.rd = rd_val;
    end
    if (wr) begin
      case (idx)
        PFC_IDX_HPF: begin
          st_d.hpf_en            = wd[PFC_HPF_EN_BIT];
          st_d.audio_corner      = wd[PFC_AUDIO_LSB+:2];
          st_d.voice_en          = wd[PFC_VOICE_EN_BIT];
          st_d.voice_corner      = wd[PFC_VOICE_LSB+:3];
        end
        PFC_IDX_EQ12: begin
          st_d.equaliser_gain[0] = wd[3:0];
          st_d.equaliser_gain[1] = wd[PFC_HI_GAIN_LSB+:4];
        end
        PFC_IDX_EQ34: begin
          st_d.equaliser_gain[2] = wd[3:0];
          st_d.equaliser_gain[3] = wd[PFC_HI_GAIN_LSB+:4];
        end
        PFC_IDX_EQ5: begin
          st_d.equaliser_enable  = wd[PFC_EQ_EN_BIT];
          st_d.equaliser_gain[4] = wd[3:0];
        end
        PFC_IDX_BIQC: begin
          st_d.biquad_chain_enable = wd[PFC_BIQ_EN_BIT];
          st_d.biquad_chain_mute   = wd[PFC_BIQ_MUTE_BIT];
        end
        PFC_IDX_BIQD: st_d.biquad_coeff_byte = wd[7:0];
        PFC_IDX_BIQA: begin
          ci                      = wd[5:0];
          st_d.biquad_coeff_index = ci;
          // Byte lane follows index parity: even low, odd high
          st_d.store[ci]          = st_q.biquad_coeff_byte;
        end
        default: st_d.rd = st_d.rd;
      endcase
    end
    // Band split filters advance once per sample
    for (int i = 0; i < PFC_BANDS - 1; i++) begin
      if (!st_q.equaliser_enable) begin
        st_d.eq_lp[i] = '0;
      end else if (smp_in_valid) begin
        st_d.eq_lp[i] = $unsigned($signed(st_q.eq_lp[i])
          + ((xe - $signed(st_q.eq_lp[i])) >>> PFC_SPLIT_SHIFT[i]));
      end
    end
    st_d.out_valid = smp_in_valid;
    if (smp_in_valid) begin
      st_d.out_data = x_final;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q                     <= '0;
      st_q.hpf_en              <= PFC_RST_HPF_EN;
      st_q.audio_corner        <= PFC_RST_AUDIO;
      st_q.voice_en            <= PFC_RST_VOICE_EN;
      st_q.voice_corner        <= PFC_RST_VOICE;
      st_q.equaliser_gain      <= {PFC_BANDS{PFC_RST_GAIN}};
      st_q.equaliser_enable    <= PFC_RST_EQ_EN;
      st_q.biquad_chain_enable <= PFC_RST_BIQ_EN;
      st_q.biquad_chain_mute   <= PFC_RST_BIQ_MUTE;
      st_q.biquad_coeff_byte   <= PFC_RST_BYTE;
      st_q.biquad_coeff_index  <= PFC_RST_INDEX;
    end else begin
      st_q <= st_d;
    end
  end

  assign smp_out_valid = st_q.out_valid;
  assign smp_out       = st_q.out_data;

endmodule

// File: bench/pfc_chk.sv
// Port checker for the playback filter configuration block
`timescale 1ns/1ps
module pfc_chk (
  // Clock and reset
  input wire logic                  sys_clk,
  input wire logic                  rst,
  // Register bus
  input wire pfc_pkg::pfc_apb_req_s apb_req,
  input wire pfc_pkg::pfc_apb_rsp_s apb_rsp,
  // Samples
  input wire logic                  smp_in_valid,
  input wire pfc_pkg::pfc_smp_t     smp_in,
  input wire logic                  smp_out_valid,
  input wire pfc_pkg::pfc_smp_t     smp_out
);
  import pfc_pkg::*;
  logic [7:0] hpf_q;
  logic [7:0] eq_q;
  logic [7:0] biq_q;
  logic       acc;
  logic       rd;
  logic       map;
  assign acc = apb_req.psel && apb_req.penable;
  assign rd  = acc && !apb_req.pwrite;
  assign map = apb_req.paddr[1:0] == 2'h0 && apb_req.paddr[7:2] >= PFC_IDX_HPF &&
               apb_req.paddr[7:2] <= PFC_IDX_BIQA;
  // Shadow of the control bytes, updated at each accepted write
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hpf_q <= 8'h80;
      eq_q  <= 8'h07;
      biq_q <= 8'h40;
    end else if (acc && apb_req.pwrite) begin
      if (apb_req.paddr == 8'h90) hpf_q <= apb_req.pwdata[7:0];
      if (apb_req.paddr == 8'h9c) eq_q <= apb_req.pwdata[7:0];
      if (apb_req.paddr == 8'ha0) biq_q <= apb_req.pwdata[7:0];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  ready_in_access_a: assert property (apb_rsp.pready == acc)
    else $error("pready not equal to access phase");
  refuse_unmapped_a: assert property (acc && !map |->
    apb_rsp.pslverr && (apb_req.pwrite || apb_rsp.prdata == 32'h0))
    else $error("unmapped access not refused");
  mapped_clean_a: assert property (acc && map |->
    !apb_rsp.pslverr && apb_rsp.prdata[31:8] == 24'h0)
    else $error("mapped access answered wrongly");
  hpf_readback_a: assert property (rd && apb_req.paddr == 8'h90 |->
    (apb_rsp.prdata[7:0] & 8'hbf) == (hpf_q & 8'hbf)) else $error("high-pass readback");
  eq_readback_a: assert property (rd && apb_req.paddr == 8'h9c |->
    (apb_rsp.prdata[7:0] & 8'h8f) == (eq_q & 8'h8f)) else $error("equaliser readback");
  biq_readback_a: assert property (rd && apb_req.paddr == 8'ha0 |->
    apb_rsp.prdata[7:6] == biq_q[7:6]) else $error("biquad control readback");
  out_latency_a: assert property (smp_out_valid == $past(smp_in_valid))
    else $error("output strobe not one cycle after input");
  out_hold_a: assert property (!smp_out_valid |-> $stable(smp_out))
    else $error("output sample moved without strobe");
  mute_out_a: assert property (smp_out_valid && biq_q[7] && biq_q[6] |->
    smp_out == 24'h0) else $error("muted chain not silent");
  pass_through_a: assert property (smp_in_valid && !hpf_q[7] && !hpf_q[3] &&
    !eq_q[7] && !biq_q[7] |=> smp_out == $past(smp_in)) else $error("bypass altered sample");
endmodule
bind pfc_top pfc_chk chk_u (.sys_clk(sys_clk), .rst(rst), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .smp_in_valid(smp_in_valid), .smp_in(smp_in),
  .smp_out_valid(smp_out_valid), .smp_out(smp_out));

// File: bench/tb_top.sv
// Self-checking bench for the playback filter configuration block
`timescale 1ns/1ps
module tb_top;
  import pfc_pkg::*;
  logic         sys_clk;
  logic         rst;
  pfc_apb_req_s req;
  pfc_apb_rsp_s rsp;
  logic         siv;
  pfc_smp_t     si;
  logic         sov;
  pfc_smp_t     so;
  int           fails;
  int           compares;
  int           cyc;
  int           x;
  int           c;
  int           i;
  int           g;
  logic [31:0]  seed;
  logic [31:0]  rd;
  logic         err;
  logic [7:0]   regm [7];
  logic [7:0]   mask [7];
  real          lpa;
  real          lpv;
  real          ya;
  real          e;
  real          f;

  pfc_top dut_u (.sys_clk(sys_clk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
    .smp_in_valid(siv), .smp_in(si), .smp_out_valid(sov), .smp_out(so));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic end_sim();
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic chk_near(input string nm, input real exp, input real tol, input pfc_smp_t got);
    real r;
    r = $itor(got) - exp;
    compares++;
    if ((^got) === 1'bx || r > tol || r < -tol) begin
      fails++;
      $display("BAD %s exp %f got %0d", nm, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    // Wait ends when pready rises; the cycle watchdog ends it if pready never comes
    do begin
      @(posedge sys_clk);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask

  task automatic wreg(input int k, input logic [7:0] v);
    apb(1'b1, 8'h90 + 8'(4 * k), {24'h0, v});
    regm[k] = v;
  endtask

  task automatic rchk(input int k);
    apb(1'b0, 8'h90 + 8'(4 * k), 32'h0);
    chk("register", {24'h0, regm[k] & mask[k]}, rd & {24'hffffff, mask[k]});
  endtask

  task automatic smp(input int xv, input real ex, input real tol);
    @(posedge sys_clk);
    siv <= 1'b1;
    si  <= 24'(xv);
    @(posedge sys_clk);
    siv <= 1'b0;
    #1;
    chk("valid", 32'h1, {31'h0, sov});
    chk_near("sample", ex, tol, so);
  endtask

  // Real-valued one-pole model; the design keeps finite precision, hence the tolerance
  task automatic run_hpf(input logic ae, input logic [1:0] a, input logic ve,
                         input logic [2:0] v);
    wreg(0, 8'h00);
    wreg(0, {ae, 1'b0, a, ve, v});
    lpa = 0.0;
    lpv = 0.0;
    repeat (24) begin
      x = int'(rnd() % 32'h200000) - 1048576;
      ya = ae ? x - lpa : x;
      if (ae) lpa += (x - lpa) / (2.0 ** PFC_AUDIO_SHIFT[a]);
      e = ve ? ya - lpv : ya;
      if (ve) lpv += (ya - lpv) / (2.0 ** PFC_VOICE_SHIFT[v]);
      smp(x, e, 40.0);
    end
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      end_sim();
    end
  end

  initial begin
    rst = 1'b1;
    req = '0;
    siv = 1'b0;
    si = '0;
    seed = 32'h30;
    regm = '{8'h80, 8'h77, 8'h77, 8'h07, 8'h40, 8'h00, 8'h00};
    mask = '{8'hbf, 8'hff, 8'hff, 8'h8f, 8'hc0, 8'hff, 8'h3f};
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    for (c = 0; c < 7; c++) rchk(c);
    for (i = 0; i < 21; i++) begin
      wreg(i % 7, 8'(rnd()));
      rchk(i % 7);
    end
    apb(1'b0, 8'hac, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, 8'h91, 32'hff);
    chk("misaligned err", 32'h1, {31'h0, err});
    rchk(0);
    wreg(3, 8'h07);
    wreg(4, 8'h40);
    for (c = 0; c < 4; c++) run_hpf(1'b1, 2'(c), 1'b0, 3'h0);
    for (c = 0; c < 8; c++) run_hpf(1'b0, 2'h0, 1'b1, 3'(c));
    run_hpf(1'b1, 2'h3, 1'b1, 3'h7);
    run_hpf(1'b0, 2'h0, 1'b0, 3'h0);
    wreg(0, 8'h00);
    for (i = 0; i < 50; i++) begin
      wreg(5, (i % 10 == 1) ? 8'h40 : 8'h00);
      wreg(6, 8'(i));
    end
    wreg(4, 8'hc0);
    smp(12345, 0.0, 0.0);
    wreg(4, 8'h80);
    for (i = 0; i < 4; i++) begin
      x = int'(rnd() % 32'h200000) - 1048576;
      smp(x, x, 0.0);
    end
    wreg(5, 8'h40);
    wreg(6, 8'h00);
    wreg(5, 8'h00);
    wreg(6, 8'h01);
    smp(-300001, $floor(-300001 / 256.0), 0.0);
    wreg(4, 8'h40);
    smp(-300001, -300001.0, 0.0);
    for (c = 0; c < 3; c++) begin
      g = c * 7 + c / 2;
      wreg(1, {4'(g), 4'(g)});
      wreg(2, {4'(g), 4'(g)});
      wreg(3, {4'h8, 4'(g)});
      f = 524288.0 * (10.0 ** ((1.5 * g - 10.5) / 20.0)) / 4.0;
      repeat (10) smp(524288, f, f / 100.0 + 16.0);
    end
    end_sim();
  end
endmodule
